// ---- mcn_map.vh ----
// Purpose: Register map, field positions, reset values and encodings
// Assumes: 32-bit word registers at byte addresses, low bits used
// Notes: Definitions only
`ifndef MCN_MAP_VH
`define MCN_MAP_VH

`define MCN_ADDR_W 8
`define MCN_A_MAIN_CONFIG 8'h00
`define MCN_A_INPUT_ENABLE 8'h04
`define MCN_A_PLL_ENABLE 8'h08
`define MCN_A_APLL_CTRL3 8'h0c
`define MCN_A_NCO_CTRL1 8'h10
`define MCN_A_FREQ_LO 8'h14
`define MCN_A_FREQ_HI 8'h18
`define MCN_A_NOMINAL_LO 8'h1c
`define MCN_A_NOMINAL_HI 8'h20
`define MCN_A_STATUS 8'h24

// Status register writable fields
`define MCN_ST_OUT_BIT 0
`define MCN_ST_DIR_BIT 1

// main_config_one fields
`define MCN_MC_SRC_LSB 0
`define MCN_MC_SRC_MSB 1
`define MCN_MC_DBL_BIT 2
`define MCN_MC_MASTER_CLOCK_SELECT_BIT 3
`define MCN_MC_RING_OSC_DISABLE_BIT 4
`define MCN_MC_W 5
`define MCN_MC_RESET 5'h00

// Oscillator pin source encodings
`define MCN_SRC_CRYSTAL 2'h1
`define MCN_SRC_EXTCLK 2'h2

// input_enable_reg: one bit per differential input
`define MCN_IE_W 3
`define MCN_IE_RESET 3'h0
`define MCN_IE_THIRD_BIT 2

// pll_enable_reg
`define MCN_PE_NCO_BIT 1
`define MCN_PE_W 2
`define MCN_PE_RESET 2'h0

// apll_ref_select, 3 bits; 11x selects the NCO block
`define MCN_REF_W 3
`define MCN_REF_RESET 3'h0
`define MCN_REF_NCO_TOP 2'h3

// nco_block_control_one mode
`define MCN_MODE_W 4
`define MCN_MODE_RESET 4'h0
`define MCN_MODE_NCO 4'h1
`define MCN_MODE_SPREAD 4'h2

// Frequency control word
`define MCN_FCW_W 40
`define MCN_FCW_HI_W 8

// Clock switch settling: cycles the busy flag stays set after a change
`define MCN_SWITCH_CYCLES 4'h8
`define MCN_CNT_W 4

`endif

// ---- mcn_word_store.v ----
// Purpose: Holds the frequency control word, registered read data
// Assumes: Single clock, write port split in a low 32-bit part and a high part
// Notes: Word reads come out of a register one cycle after the select
`timescale 1ns/100ps
`include "mcn_map.vh"
module mcn_word_store #(
    parameter WORD_W = 40,
    parameter [WORD_W-1:0] RESET_WORD = 40'h0
) (
    input wire clk,
    input wire rst,
    input wire wr_lo,
    input wire wr_hi,
    input wire [31:0] wdata,
    output reg [WORD_W-1:0] word,
    output reg [WORD_W-1:0] word_q
);
////////////////////////////////////////////////////////////////////////
always @(posedge clk or posedge rst) begin
    if (rst) begin
        word <= RESET_WORD;
        word_q <= RESET_WORD;
    end else begin
        if (wr_lo)
            word[31:0] <= wdata;
        if (wr_hi)
            word[WORD_W-1:32] <= wdata[WORD_W-33:0];
        word_q <= word;
    end
end
endmodule // mcn_word_store

// ---- mcn_clock_ctrl.v ----
// Purpose: Master clock source and NCO block control with register port
// Assumes: Host port synchronous to CLK_SYS; analog blocks take enables
// Notes: Read data stand one cycle after the read strobe
//
// Operation
// (RQ1) Crystal driver enabled only while source field holds crystal code.
// (RQ2) Oscillator pin enabled as single-ended clock input for external code.
// (RQ3) Doubler bit set doubles the selected crystal or pin clock.
// (RQ4) After reset registers and host port run from the ring oscillator.
// (RQ5) Software sets master clock select once the pin clock is stable.
// (RQ6) Ring oscillator disable bit written one powers the ring down; code does so only when master clock select is written one too.
// (RQ7) APLL-only mode needs no pin clock; ring oscillator stays on.
// (RQ8) Each of three differential inputs enabled by its own bit.
// (RQ9) Third input positive pin serves as general pin when not a clock.
// (RQ10) NCO block enabled by its bit in the PLL enable register.
// (RQ11) NCO output feeds APLL reference when reference select is 11x.
// (RQ12) Block mode 0001 runs plain NCO mode.
// (RQ13) Block mode 0010 runs spread-spectrum mode.
// (RQ14) 40-bit unsigned control word sets NCO frequency, finer than 0.01ppb.
// (RQ15) Control word at nominal gives zero offset to the pin master clock.
// (RQ16) Software reads nominal word back before retuning.
// (RQ17) New word is nominal times one plus ppm over 1e6, rounded.
// (RQ18) Keep word within 1000ppm of nominal, 500ppm of previous.
// (RQ19) With spread also on, total deviation within 5000ppm.
// (RQ20) Host accesses stay intact while clock source changes.
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`include "mcn_map.vh"
module mcn_clock_ctrl #(
    parameter [`MCN_FCW_W-1:0] NOMINAL_WORD = 40'h0100000000
) (
    input wire CLK_SYS,
    input wire RST,
    input wire [`MCN_ADDR_W-1:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [31:0] RDATA,
    output reg XTAL_DRIVER_EN,
    output reg OSC_PIN_INPUT_EN,
    output reg DOUBLER_EN,
    output reg RING_OSC_EN,
    output reg REG_CLK_FROM_PIN,
    output reg NCO_MASTER_FROM_PIN,
    output reg [`MCN_IE_W-1:0] INPUT_CLK_EN,
    input wire GENERAL_PIN_THREE_IN,
    output reg GENERAL_PIN_THREE_OUT,
    output reg GENERAL_PIN_THREE_OE_N,
    output reg NCO_BLOCK_EN,
    output reg APLL_REF_FROM_NCO,
    output reg [`MCN_REF_W-1:0] APLL_REF_SEL,
    output reg NCO_MODE,
    output reg SPREAD_MODE,
    output reg [`MCN_FCW_W-1:0] FREQ_WORD,
    output reg SWITCH_BUSY
);
////////////////////////////////////////////////////////////////////////
// Register state
reg [`MCN_MC_W-1:0] main_config_one;
reg [`MCN_IE_W-1:0] input_enable_reg;
reg [`MCN_PE_W-1:0] pll_enable_reg;
reg [`MCN_REF_W-1:0] apll_ref_select;
reg [`MCN_MODE_W-1:0] nco_mode;
reg gp_out;
reg gp_dir_out;
reg [`MCN_CNT_W-1:0] switch_cnt;
wire [`MCN_FCW_W-1:0] freq_control_word;
wire [`MCN_FCW_W-1:0] freq_word_q;
wire wr_main = WR && (ADDR == `MCN_A_MAIN_CONFIG);
wire [1:0] osc_pin_source_mode =
    main_config_one[`MCN_MC_SRC_MSB:`MCN_MC_SRC_LSB];
wire master_clock_select = main_config_one[`MCN_MC_MASTER_CLOCK_SELECT_BIT];
wire ring_osc_disable = main_config_one[`MCN_MC_RING_OSC_DISABLE_BIT];
wire [1:0] new_src = WDATA[`MCN_MC_SRC_MSB:`MCN_MC_SRC_LSB];
// A change of the clock that runs the register side
wire clk_change = wr_main &&
    ((WDATA[`MCN_MC_MASTER_CLOCK_SELECT_BIT] != master_clock_select) ||
     (WDATA[`MCN_MC_RING_OSC_DISABLE_BIT] != ring_osc_disable) ||
     (new_src != osc_pin_source_mode));
// Ring must not be stopped while the pin is not yet the master clock,
// else the host port would lose its only clock.
wire ring_off_ok = WDATA[`MCN_MC_MASTER_CLOCK_SELECT_BIT];

////////////////////////////////////////////////////////////////////////
// Frequency word store
mcn_word_store #(
    .WORD_W(`MCN_FCW_W),
    .RESET_WORD(NOMINAL_WORD)
) u_word (
    .clk(CLK_SYS),
    .rst(RST),
    .wr_lo(WR && (ADDR == `MCN_A_FREQ_LO)), // RQ14
    .wr_hi(WR && (ADDR == `MCN_A_FREQ_HI)), // RQ14
    .wdata(WDATA),
    .word(freq_control_word),
    .word_q(freq_word_q)
);

////////////////////////////////////////////////////////////////////////
// Register writes
always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        main_config_one <= `MCN_MC_RESET; // RQ4
        input_enable_reg <= `MCN_IE_RESET;
        pll_enable_reg <= `MCN_PE_RESET;
        apll_ref_select <= `MCN_REF_RESET;
        nco_mode <= `MCN_MODE_RESET;
        gp_out <= 1'b0;
        gp_dir_out <= 1'b0;
    end else if (WR) begin
        case (ADDR)
            `MCN_A_MAIN_CONFIG: begin
                main_config_one <= WDATA[`MCN_MC_W-1:0];
                // RQ7: ring stays on unless the pin clock takes over
                if (!ring_off_ok)
                    main_config_one[`MCN_MC_RING_OSC_DISABLE_BIT] <= 1'b0; // RQ7
            end
            `MCN_A_INPUT_ENABLE: input_enable_reg <= WDATA[`MCN_IE_W-1:0];
            `MCN_A_PLL_ENABLE: pll_enable_reg <= WDATA[`MCN_PE_W-1:0];
            `MCN_A_APLL_CTRL3: apll_ref_select <= WDATA[`MCN_REF_W-1:0];
            `MCN_A_NCO_CTRL1: nco_mode <= WDATA[`MCN_MODE_W-1:0];
            `MCN_A_STATUS: begin
                gp_out <= WDATA[`MCN_ST_OUT_BIT];
                gp_dir_out <= WDATA[`MCN_ST_DIR_BIT];
            end
            default: begin
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
// Clock switch guard: a change of the register clock source raises a
// busy window; the source switch itself is glitch-free outside.
always @(posedge CLK_SYS or posedge RST) begin
    if (RST)
        switch_cnt <= {`MCN_CNT_W{1'b0}};
    else if (clk_change)
        switch_cnt <= `MCN_SWITCH_CYCLES; // RQ20
    else if (switch_cnt != {`MCN_CNT_W{1'b0}})
        switch_cnt <= switch_cnt - 1'b1;
end

////////////////////////////////////////////////////////////////////////
// Read path: data stand one cycle after the strobe
always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        RDATA <= 32'h0;
    end else if (RD) begin
        case (ADDR)
            `MCN_A_MAIN_CONFIG: RDATA <= {27'h0, main_config_one};
            `MCN_A_INPUT_ENABLE: RDATA <= {29'h0, input_enable_reg};
            `MCN_A_PLL_ENABLE: RDATA <= {30'h0, pll_enable_reg};
            `MCN_A_APLL_CTRL3: RDATA <= {29'h0, apll_ref_select};
            `MCN_A_NCO_CTRL1: RDATA <= {28'h0, nco_mode};
            `MCN_A_FREQ_LO: RDATA <= freq_control_word[31:0]; // RQ14
            `MCN_A_FREQ_HI:
                RDATA <= {24'h0, freq_control_word[`MCN_FCW_W-1:32]};
            `MCN_A_NOMINAL_LO: RDATA <= NOMINAL_WORD[31:0]; // RQ16
            `MCN_A_NOMINAL_HI:
                RDATA <= {24'h0, NOMINAL_WORD[`MCN_FCW_W-1:32]}; // RQ16
            `MCN_A_STATUS:
                RDATA <= {28'h0, (switch_cnt != {`MCN_CNT_W{1'b0}}),
                          GENERAL_PIN_THREE_IN, gp_dir_out, gp_out};
            default: RDATA <= 32'h0;
        endcase
    end else begin
        RDATA <= 32'h0;
    end
end

////////////////////////////////////////////////////////////////////////
// Clock source and block controls, all registered
always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        XTAL_DRIVER_EN <= 1'b0;
        OSC_PIN_INPUT_EN <= 1'b0;
        DOUBLER_EN <= 1'b0;
        RING_OSC_EN <= 1'b1;
        REG_CLK_FROM_PIN <= 1'b0;
        NCO_MASTER_FROM_PIN <= 1'b0;
        INPUT_CLK_EN <= `MCN_IE_RESET;
        GENERAL_PIN_THREE_OUT <= 1'b0;
        GENERAL_PIN_THREE_OE_N <= 1'b1;
        NCO_BLOCK_EN <= 1'b0;
        APLL_REF_FROM_NCO <= 1'b0;
        APLL_REF_SEL <= `MCN_REF_RESET;
        NCO_MODE <= 1'b0;
        SPREAD_MODE <= 1'b0;
        FREQ_WORD <= NOMINAL_WORD;
        SWITCH_BUSY <= 1'b0;
    end else begin
        XTAL_DRIVER_EN <= (osc_pin_source_mode == `MCN_SRC_CRYSTAL); // RQ1
        OSC_PIN_INPUT_EN <= (osc_pin_source_mode == `MCN_SRC_EXTCLK); // RQ2
        // Doubling only makes sense with a live crystal or pin source
        DOUBLER_EN <= main_config_one[`MCN_MC_DBL_BIT] &&
            ((osc_pin_source_mode == `MCN_SRC_CRYSTAL) ||
             (osc_pin_source_mode == `MCN_SRC_EXTCLK)); // RQ3
        RING_OSC_EN <= !ring_osc_disable; // RQ6 RQ7
        // Register side leaves the ring only when it is being shut down
        REG_CLK_FROM_PIN <= master_clock_select && ring_osc_disable; // RQ4
        NCO_MASTER_FROM_PIN <= master_clock_select; // RQ5
        INPUT_CLK_EN <= input_enable_reg; // RQ8
        GENERAL_PIN_THREE_OUT <= gp_out; // RQ9
        GENERAL_PIN_THREE_OE_N <=
            input_enable_reg[`MCN_IE_THIRD_BIT] || !gp_dir_out; // RQ9
        NCO_BLOCK_EN <= pll_enable_reg[`MCN_PE_NCO_BIT]; // RQ10
        APLL_REF_FROM_NCO <= (apll_ref_select[`MCN_REF_W-1:1] ==
            `MCN_REF_NCO_TOP); // RQ11
        APLL_REF_SEL <= apll_ref_select;
        NCO_MODE <= (nco_mode == `MCN_MODE_NCO); // RQ12
        SPREAD_MODE <= (nco_mode == `MCN_MODE_SPREAD); // RQ13
        // Word passes unchanged, so nominal gives zero offset
        FREQ_WORD <= freq_word_q; // RQ15
        SWITCH_BUSY <= (switch_cnt != {`MCN_CNT_W{1'b0}}); // RQ20
    end
end
endmodule // mcn_clock_ctrl

// ---- mcn_ctrl_checker.sv ----
// Purpose: Port-level assertions for the clock control block
// Assumes: Outputs follow a register write two edges after it is taken
// Notes: Bound to the top module from the testbench
`timescale 1ns/100ps
module mcn_ctrl_checker (
    input wire CLK_SYS,
    input wire RST,
    input wire [7:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire RD,
    input wire [31:0] RDATA,
    input wire XTAL_DRIVER_EN,
    input wire OSC_PIN_INPUT_EN,
    input wire RING_OSC_EN,
    input wire NCO_BLOCK_EN,
    input wire APLL_REF_FROM_NCO,
    input wire NCO_MODE,
    input wire SPREAD_MODE
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////////////
    a_xtal_on: assert property (WR && ADDR == 8'h00 &&
        WDATA[1:0] == 2'h1 |-> ##2 XTAL_DRIVER_EN) else $error("xtal off");
    a_xtal_off: assert property (WR && ADDR == 8'h00 &&
        WDATA[1:0] != 2'h1 |-> ##2 !XTAL_DRIVER_EN) else $error("xtal on");
    a_pin_input: assert property (WR && ADDR == 8'h00 &&
        WDATA[1:0] == 2'h2 |-> ##2 OSC_PIN_INPUT_EN && !XTAL_DRIVER_EN)
        else $error("pin input wrong");
    a_ring_start: assert property ($fell(RST) |-> RING_OSC_EN [*3])
        else $error("ring off after reset");
    a_ring_kept: assert property (WR && ADDR == 8'h00 &&
        WDATA[4:3] == 2'h2 |-> ##2 RING_OSC_EN) else $error("ring lost");
    a_ring_down: assert property (WR && ADDR == 8'h00 &&
        WDATA[4:3] == 2'h3 |-> ##2 !RING_OSC_EN) else $error("ring on");
    a_nco_enable: assert property (WR && ADDR == 8'h08 &&
        WDATA[1] |-> ##2 NCO_BLOCK_EN) else $error("nco block off");
    a_ref_nco: assert property (WR && ADDR == 8'h0c &&
        WDATA[2:1] == 2'h3 |-> ##2 APLL_REF_FROM_NCO) else $error("ref");
    a_mode_nco: assert property (WR && ADDR == 8'h10 &&
        WDATA[3:0] == 4'h1 |-> ##2 NCO_MODE && !SPREAD_MODE)
        else $error("nco mode");
    a_mode_spread: assert property (WR && ADDR == 8'h10 &&
        WDATA[3:0] == 4'h2 |-> ##2 SPREAD_MODE && !NCO_MODE)
        else $error("spread mode");
    a_rdata_idle: assert property (!RD |=> RDATA == 32'h0)
        else $error("read data outside slot");
    c_ring_down: cover property (WR && ADDR == 8'h00 && WDATA[4:3] == 2'h3);
    c_ref_nco: cover property (APLL_REF_FROM_NCO && NCO_BLOCK_EN);
    c_spread: cover property (SPREAD_MODE);
endmodule // mcn_ctrl_checker

// ---- mcn_host_model.sv ----
// Purpose: Host software model on the register port
// Assumes: Each access starts right after a rising edge
// Notes: One idle cycle follows every strobe; released data is inverted
`timescale 1ns/100ps
module mcn_host_model (
    input wire CLK_SYS,
    output reg [7:0] ADDR,
    output reg [31:0] WDATA,
    output reg WR,
    output reg RD,
    input wire [31:0] RDATA
);
    initial begin
        ADDR = 8'h00;
        WDATA = 32'h0;
        WR = 1'b0;
        RD = 1'b0;
    end
    task wr(input [7:0] a, input [31:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK_SYS);
        WR <= 1'b0;
        WDATA <= ~d;
        @(posedge CLK_SYS);
    endtask
    task rd(input [7:0] a, output [31:0] d);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK_SYS);
        RD <= 1'b0;
        @(posedge CLK_SYS);
        d = RDATA;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Always scaled from the nominal word so errors never accumulate
    function [39:0] retune(input [39:0] nom, input integer ppm);
        longint n;
        longint d;
        n = nom;
        d = n * ppm;
        d = d + ((d < 0) ? -500000 : 500000);
        retune = n + d / 1000000;
    endfunction
endmodule // mcn_host_model

// ---- tb_master_clock_and_nco_control.sv ----
// Purpose: Self-checking bench for the clock control block
// Assumes: Host model owns the register port
// Notes: Seeded random values mixed with boundary cases
`timescale 1ns/100ps
`include "mcn_map.vh"
module tb_master_clock_and_nco_control;
    localparam [39:0] NOM = 40'h0123456789;
    reg CLK_SYS = 1'b0;
    reg RST = 1'b1;
    reg gp_in = 1'b0;
    wire [7:0] ADDR;
    wire [31:0] WDATA, RDATA;
    wire WR, RD, xtal, osc, doubler_enable, ring, regpin, ncopin, gp_out, gp_oe_n;
    wire nco_en, ref_nco, nco_m, spr_m, busy;
    wire [2:0] ice, refsel;
    wire [39:0] fw;
    integer num_errors = 0, cmp_count = 0, seed, i, ppm;
    logic [31:0] r, v;
    logic [39:0] nom, w;
    always #12.5 CLK_SYS = ~CLK_SYS;
    mcn_host_model i_host (.CLK_SYS(CLK_SYS), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA));
    mcn_clock_ctrl #(.NOMINAL_WORD(NOM)) i_dut (.CLK_SYS(CLK_SYS),
        .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .XTAL_DRIVER_EN(xtal), .OSC_PIN_INPUT_EN(osc),
        .DOUBLER_EN(doubler_enable), .RING_OSC_EN(ring), .REG_CLK_FROM_PIN(regpin),
        .NCO_MASTER_FROM_PIN(ncopin), .INPUT_CLK_EN(ice),
        .GENERAL_PIN_THREE_IN(gp_in), .GENERAL_PIN_THREE_OUT(gp_out),
        .GENERAL_PIN_THREE_OE_N(gp_oe_n), .NCO_BLOCK_EN(nco_en),
        .APLL_REF_FROM_NCO(ref_nco), .APLL_REF_SEL(refsel),
        .NCO_MODE(nco_m), .SPREAD_MODE(spr_m), .FREQ_WORD(fw),
        .SWITCH_BUSY(busy));
    ////////////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [39:0] s, input logic [39:0] e);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task put(input [7:0] a, input [31:0] d);
        @(posedge CLK_SYS);
        i_host.wr(a, d);
        @(negedge CLK_SYS);
    endtask
    task get(input [7:0] a, output [31:0] d);
        @(posedge CLK_SYS);
        i_host.rd(a, d);
    endtask
    task give_verdict;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #300000;
        num_errors++;
        give_verdict;
    end
    initial begin
        seed = 32'h1bd5;
        repeat (10) @(posedge CLK_SYS);
        RST <= 1'b0;
        @(negedge CLK_SYS);
        chk("ring", ring, 1'b1);
        chk("word", fw, NOM);
        for (i = 0; i < 8; i++) begin
            put(`MCN_A_MAIN_CONFIG, i);
            chk("xtal", xtal, i[1:0] == 2'h1);
            chk("osc", osc, i[1:0] == 2'h2);
            chk("dbl", doubler_enable, i[2] && (i[1:0] == 2'h1 || i[1:0] == 2'h2));
            chk("busy", busy, i != 0);
            repeat (10) @(posedge CLK_SYS);
        end
        put(`MCN_A_MAIN_CONFIG, 32'h12);
        chk("ring", ring, 1'b1);
        repeat (10) @(posedge CLK_SYS);
        put(`MCN_A_MAIN_CONFIG, 32'h1a);
        chk("ring", ring, 1'b0);
        chk("regpin", regpin, 1'b1);
        chk("ncopin", ncopin, 1'b1);
        chk("busy", busy, 1'b1);
        repeat (10) @(posedge CLK_SYS);
        for (i = 0; i < 4; i++) begin
            v = $random(seed);
            put(`MCN_A_INPUT_ENABLE, v);
            chk("ice", ice, v[2:0]);
            get(`MCN_A_INPUT_ENABLE, r);
            chk("ice rd", r, {29'h0, v[2:0]});
        end
        gp_in <= 1'b1;
        put(`MCN_A_INPUT_ENABLE, 32'h3);
        put(`MCN_A_STATUS, 32'h3);
        chk("gp oe", gp_oe_n, 1'b0);
        chk("gp out", gp_out, 1'b1);
        get(`MCN_A_STATUS, r);
        chk("gp in", r[2], 1'b1);
        chk("busy rd", r[3], 1'b0);
        put(`MCN_A_INPUT_ENABLE, 32'h4);
        chk("gp oe", gp_oe_n, 1'b1);
        for (i = 0; i < 16; i++) begin
            put(`MCN_A_PLL_ENABLE, i);
            chk("nco en", nco_en, i[1]);
            put(`MCN_A_APLL_CTRL3, i);
            chk("ref", ref_nco, i[2:1] == 2'h3);
            chk("refsel", refsel, i[2:0]);
            put(`MCN_A_NCO_CTRL1, i);
            chk("nco", nco_m, i == 1);
            chk("spread", spr_m, i == 2);
        end
        put(`MCN_A_NCO_CTRL1, `MCN_MODE_NCO);
        chk("nco", nco_m, 1'b1);
        get(`MCN_A_NOMINAL_LO, r);
        nom[31:0] = r;
        get(`MCN_A_NOMINAL_HI, r);
        nom[39:32] = r[7:0];
        chk("nominal", nom, NOM);
        for (i = 0; i < 8; i++) begin
            ppm = (i < 2) ? 250 - 500 * i : $random(seed) % 250;
            w = i_host.retune(nom, ppm);
            put(`MCN_A_FREQ_LO, w[31:0]);
            put(`MCN_A_FREQ_HI, {24'h0, w[39:32]});
            @(negedge CLK_SYS);
            chk("fw", fw, w);
        end
        get(8'h30, r);
        chk("unmapped", r, 32'h0);
        give_verdict;
    end
endmodule // tb_master_clock_and_nco_control
bind mcn_clock_ctrl mcn_ctrl_checker i_chk (.CLK_SYS(CLK_SYS), .RST(RST),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .XTAL_DRIVER_EN(XTAL_DRIVER_EN), .OSC_PIN_INPUT_EN(OSC_PIN_INPUT_EN),
    .RING_OSC_EN(RING_OSC_EN), .NCO_BLOCK_EN(NCO_BLOCK_EN),
    .APLL_REF_FROM_NCO(APLL_REF_FROM_NCO), .NCO_MODE(NCO_MODE),
    .SPREAD_MODE(SPREAD_MODE));
